// File: fpi_pkg.sv
/*
 * Shared constants and carrier types of the framer status block:
 * register addresses, field positions, reset values and grouped signals.
 * Assumes an 8-bit host data bus and a 15-bit host address bus.
 */
// ==========================================================================
// Package
// ==========================================================================
package fpi_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int CNT_NUM = 7;

    // Block-level interrupt registers
    localparam logic [14:0] ADDR_BLK_EN = 15'h1104;
    localparam logic [14:0] ADDR_BLK_STS = 15'h1105;
    // Source-level interrupt registers
    localparam logic [14:0] ADDR_RXF1_EN = 15'h1112;
    localparam logic [14:0] ADDR_RXF1_STS = 15'h1113;
    localparam logic [14:0] ADDR_RXF2_EN = 15'h1114;
    localparam logic [14:0] ADDR_RXF2_STS = 15'h1115;
    localparam logic [14:0] ADDR_TXF_EN = 15'h1133;
    localparam logic [14:0] ADDR_TXF_STS = 15'h1134;
    localparam logic [14:0] ADDR_PLCP_EN = 15'h1191;
    localparam logic [14:0] ADDR_PLCP_STS = 15'h1192;
    localparam logic [14:0] ADDR_LIU_EN = 15'h1301;
    localparam logic [14:0] ADDR_LIU_STS = 15'h1302;
    // Counters: upper byte at base + 2*i, lower byte at base + 2*i + 1
    localparam logic [14:0] ADDR_CNT_BASE = 15'h1150;
    localparam logic [14:0] ADDR_HOLD = 15'h116C;

    // Counter indices
    localparam int CNT_EXZ = 0;
    localparam int CNT_LCV = 1;
    localparam int CNT_FRM = 2;
    localparam int CNT_PAR = 3;
    localparam int CNT_FEBE = 4;
    localparam int CNT_CPB = 5;
    localparam int CNT_PRBS = 6;

    // Bit positions in the block-level registers
    localparam int BLK_TXF = 0;
    localparam int BLK_RXF = 1;
    localparam int BLK_PLCP = 2;
    localparam int BLK_LIU = 3;

    localparam logic [7:0] BLK_EN_RST = 8'h00;
    localparam logic [7:0] SRC_EN_RST = 8'h00;
    localparam logic [7:0] HOLD_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;

    typedef struct packed {
        logic rdStb;
        logic wrStb;
        logic [14:0] addr;
        logic [7:0] wdata;
    } fpi_acc_s;

    typedef struct packed {
        logic hit;
        logic [7:0] data;
    } fpi_rd_s;

    typedef struct packed {
        logic lapdDone;
        logic feacDone;
    } fpi_txf_evt_s;

    typedef struct packed {
        logic ferf;
        logic ais;
        logic oof;
        logic los;
    } fpi_rxf_def_s;

    typedef struct packed {
        logic oneSecond;
        logic lapdNew;
        logic feacRemoved;
        logic feacValid;
        logic trailTraceChange;
        logic febeEvent;
        logic bip8Err;
        logic bip4Err;
        logic cpBitErr;
        logic pBitErr;
    } fpi_rxf_evt_s;

    typedef struct packed {
        logic rai;
        logic lof;
        logic oof;
    } fpi_plcp_def_s;

    typedef struct packed {
        logic transmitDriveMonitor;
        logic los;
        logic receiveLockLost;
        logic jitterFifoLimitAlarm;
    } fpi_liu_def_s;

endpackage : fpi_pkg

// File: fpi_irq_group.sv
/*
 * One source-level interrupt group: sticky status bits, enable bits,
 * clear-on-read of the status register.
 * Assumes event inputs are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
// ==========================================================================
// Source-level group
// ==========================================================================
module fpi_irq_group
    import fpi_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter logic [14:0] EN_ADDR = 15'h0000,
    parameter logic [14:0] STS_ADDR = 15'h0001
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire fpi_acc_s acc,
    input wire logic [WIDTH-1:0] srcEvent,
    output logic pending,
    output fpi_rd_s rdAns
);

    logic [WIDTH-1:0] sts_ff;
    logic [WIDTH-1:0] en_ff;
    logic [WIDTH-1:0] nxt_sts;
    logic [WIDTH-1:0] nxt_en;
    wire enHit = (acc.addr == EN_ADDR);
    wire stsHit = (acc.addr == STS_ADDR);
    wire stsClr = acc.rdStb & stsHit;

    // New events win over a clearing read in the same cycle
    assign nxt_sts = srcEvent | (stsClr ? '0 : sts_ff); // R18
    assign nxt_en = (acc.wrStb & enHit) ? acc.wdata[WIDTH-1:0] : en_ff; // R9
    assign pending = |(sts_ff & en_ff); // R18
    assign rdAns.hit = enHit | stsHit;
    assign rdAns.data = stsHit ? DATA_W'(sts_ff) : (enHit ? DATA_W'(en_ff) : 8'h00);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sts_ff <= '0;
            en_ff <= SRC_EN_RST[WIDTH-1:0];
        end else begin
            sts_ff <= nxt_sts;
            en_ff <= nxt_en;
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    stsSticky_a: assert property (@(posedge clock) disable iff (!arst_n) // R18
        (|srcEvent) |=> ((sts_ff & $past(srcEvent)) == $past(srcEvent)))
        else $error("event not latched in status");
    stsClear_a: assert property (@(posedge clock) disable iff (!arst_n) // R18
        (stsClr && srcEvent == '0) |=> (sts_ff == '0))
        else $error("status read did not clear");

endmodule : fpi_irq_group

// File: fpi_perf_counters.sv
/*
 * Bank of 16-bit clear-on-read performance counters with a shared byte
 * holding register for split reads.
 * Assumes increment inputs are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
// ==========================================================================
// Counter bank
// ==========================================================================
module fpi_perf_counters
    import fpi_pkg::*;
#(
    parameter int NUM = CNT_NUM
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire fpi_acc_s acc,
    input wire logic [NUM-1:0] cntInc,
    output fpi_rd_s rdAns
);

    logic [CNT_W-1:0] cnt_ff [NUM];
    logic [7:0] hold_ff;
    logic [NUM-1:0] msbHit;
    logic [NUM-1:0] lsbHit;
    logic [7:0] cntByte [NUM];
    logic [7:0] otherByte [NUM];
    logic [7:0] nxt_hold;
    logic [7:0] rdByte;
    wire holdHit = (acc.addr == ADDR_HOLD);
    wire anyCntHit = |(msbHit | lsbHit);

    function automatic logic [14:0] cntAddr(input int idx, input logic lsb);
        cntAddr = ADDR_CNT_BASE + 15'(2 * idx) + {14'h0000, lsb};
    endfunction : cntAddr

    for (genvar i = 0; i < NUM; i++) begin : g_cnt
        wire rdHit = acc.rdStb & (msbHit[i] | lsbHit[i]);
        wire sat = &cnt_ff[i];
        assign msbHit[i] = (acc.addr == cntAddr(i, 1'b0));
        assign lsbHit[i] = (acc.addr == cntAddr(i, 1'b1));
        assign cntByte[i] = msbHit[i] ? cnt_ff[i][15:8] : cnt_ff[i][7:0]; // R3
        assign otherByte[i] = msbHit[i] ? cnt_ff[i][7:0] : cnt_ff[i][15:8];

        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                cnt_ff[i] <= CNT_RST;
            end else if (rdHit) begin
                // Whole counter clears; an increment in the same cycle survives
                cnt_ff[i] <= {15'h0000, cntInc[i]}; // R1 R4 R7
            end else if (cntInc[i] && !sat) begin
                cnt_ff[i] <= cnt_ff[i] + 16'h0001;
            end
        end
    end

    always_comb begin
        nxt_hold = hold_ff; // R19
        rdByte = 8'h00;
        for (int i = 0; i < NUM; i++) begin
            if (msbHit[i] | lsbHit[i]) begin
                rdByte = cntByte[i];
                if (acc.rdStb) begin
                    nxt_hold = otherByte[i]; // R5
                end
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hold_ff <= HOLD_RST;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    assign rdAns.hit = anyCntHit | holdHit;
    assign rdAns.data = holdHit ? hold_ff : rdByte; // R6

    // ======================================================================
    // Checks
    // ======================================================================
    cntClear_a: assert property (@(posedge clock) disable iff (!arst_n) // R4
        (acc.rdStb && msbHit[0] && !cntInc[0]) |=> (cnt_ff[0] == 16'h0000))
        else $error("counter not cleared by read");
    holdCapture_a: assert property (@(posedge clock) disable iff (!arst_n) // R5
        (acc.rdStb && lsbHit[1]) |=> (hold_ff == $past(cnt_ff[1][15:8])))
        else $error("holding byte not captured");
    holdKeep_a: assert property (@(posedge clock) disable iff (!arst_n) // R19
        !(acc.rdStb && anyCntHit) |=> $stable(hold_ff))
        else $error("holding byte changed without counter read");
    cntRead_c: cover property (@(posedge clock) disable iff (!arst_n)
        (acc.rdStb && msbHit[2]) ##[1:20] (acc.rdStb && holdHit));

endmodule : fpi_perf_counters

// File: fpi_framer_status.sv
/*
 * Framer status top: host bus slave, performance counter read-out and the
 * two-level interrupt hierarchy onto one request output.
 * Assumes asynchronous host pins (synchronised here) and event, defect and
 * increment inputs from framer logic on the same clock.
 */
`timescale 1ns/1ps
// ==========================================================================
// Top module
// ==========================================================================
// How it works
// R1: Every performance counter is sixteen bits and clears when the host reads it.
// R2: Host reads a full counter as two successive byte reads.
// R3: First read may target upper or lower byte; that byte is returned.
// R4: First byte read zeroes the whole sixteen-bit counter.
// R5: That read copies the unreturned byte into the shared holding register.
// R6: Host takes the second byte from the holding register.
// R7: Split read applies to all seven error and event counters.
// R8: One interrupt request output, asserted while any enabled condition pends.
// R9: Interrupts have block and source levels, each with status and enable.
// R10: Transmit framer interrupts on alarm message done and link message done.
// R11: Receive framer interrupts on defect changes and trail-trace change.
// R12: Receive framer interrupts on parity, BIP and far-end block errors.
// R13: Receive framer interrupts on alarm message valid/removed, new message, each second.
// R14: Receive PLCP interrupts on out-of-frame, loss-of-frame, remote-alarm changes.
// R15: Line interface interrupts on FIFO limit, lock loss, signal loss, drive monitor changes.
// R16: Block enable at 0x1104, block status at the next address.
// R17: Line interface status at 0x1302, enable just before it.
// R18: Source drives request only with both enables; status sticks until read.
// R19: Holding register keeps its byte until the next first-byte counter read.
module fpi_framer_status
    import fpi_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic hostCsN,
    input wire logic hostRdN,
    input wire logic hostWrN,
    input wire logic [14:0] hostAddr,
    input wire logic [7:0] hostDataIn,
    output logic [7:0] hostDataOut,
    output logic hostDataOe,
    output logic hostReadyN,
    output logic irqReqN,
    input wire fpi_txf_evt_s txfEvent,
    input wire fpi_rxf_def_s rxfDefect,
    input wire fpi_rxf_evt_s rxfEvent,
    input wire fpi_plcp_def_s plcpDefect,
    input wire fpi_liu_def_s liuDefect,
    input wire logic [CNT_NUM-1:0] cntInc
);

    // ======================================================================
    // Host pin synchronisers
    // ======================================================================
    logic [25:0] pinMeta_ff;
    logic [25:0] pinSync_ff;
    logic rdReqPrev_ff;
    logic wrReqPrev_ff;
    logic rdReqOld_ff;
    logic wrReqOld_ff;
    wire [25:0] pinRaw = {hostCsN, hostRdN, hostWrN, hostAddr, hostDataIn};
    wire csAct = ~pinSync_ff[25];
    wire rdReq = csAct & ~pinSync_ff[24];
    wire wrReq = csAct & ~pinSync_ff[23] & ~rdReq;
    wire [14:0] syncAddr = pinSync_ff[22:8];
    wire [7:0] syncData = pinSync_ff[7:0];
    // Strobe one cycle after the synced request, so address and data have
    // passed both synchroniser stages settled when they are decoded
    wire rdStb = rdReq & rdReqPrev_ff & ~rdReqOld_ff;
    wire wrStb = wrReq & wrReqPrev_ff & ~wrReqOld_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta_ff <= 26'h3FFFFFF;
            pinSync_ff <= 26'h3FFFFFF;
            rdReqPrev_ff <= 1'b0;
            wrReqPrev_ff <= 1'b0;
            rdReqOld_ff <= 1'b0;
            wrReqOld_ff <= 1'b0;
        end else begin
            pinMeta_ff <= pinRaw;
            pinSync_ff <= pinMeta_ff;
            rdReqPrev_ff <= rdReq;
            wrReqPrev_ff <= wrReq;
            rdReqOld_ff <= rdReqPrev_ff;
            wrReqOld_ff <= wrReqPrev_ff;
        end
    end

    fpi_acc_s acc;
    assign acc.rdStb = rdStb;
    assign acc.wrStb = wrStb;
    assign acc.addr = syncAddr;
    assign acc.wdata = syncData;

    // ======================================================================
    // Change detection of defect levels
    // ======================================================================
    fpi_rxf_def_s rxfPrev_ff;
    fpi_plcp_def_s plcpPrev_ff;
    fpi_liu_def_s liuPrev_ff;
    wire [3:0] rxfChg = rxfDefect ^ rxfPrev_ff; // R11
    wire [2:0] plcpChg = plcpDefect ^ plcpPrev_ff; // R14
    wire [3:0] liuChg = liuDefect ^ liuPrev_ff; // R15

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rxfPrev_ff <= '0;
            plcpPrev_ff <= '0;
            liuPrev_ff <= '0;
        end else begin
            rxfPrev_ff <= rxfDefect;
            plcpPrev_ff <= plcpDefect;
            liuPrev_ff <= liuDefect;
        end
    end

    // ======================================================================
    // Source-level groups
    // ======================================================================
    wire [1:0] txfSrc = {txfEvent.lapdDone, txfEvent.feacDone}; // R10
    wire [7:0] rxf1Src = {rxfEvent.lapdNew, rxfEvent.feacRemoved, rxfEvent.feacValid,
                          rxfEvent.trailTraceChange, rxfChg}; // R11 R13
    wire [5:0] rxf2Src = {rxfEvent.oneSecond, rxfEvent.febeEvent, rxfEvent.bip8Err,
                          rxfEvent.bip4Err, rxfEvent.cpBitErr, rxfEvent.pBitErr}; // R12 R13
    logic txfPend;
    logic rxf1Pend;
    logic rxf2Pend;
    logic plcpPend;
    logic liuPend;
    fpi_rd_s txfAns;
    fpi_rd_s rxf1Ans;
    fpi_rd_s rxf2Ans;
    fpi_rd_s plcpAns;
    fpi_rd_s liuAns;
    fpi_rd_s cntAns;

    fpi_irq_group #(
        .WIDTH(2),
        .EN_ADDR(ADDR_TXF_EN),
        .STS_ADDR(ADDR_TXF_STS)
    ) u_txf (
        .clock(clock),
        .arst_n(arst_n),
        .acc(acc),
        .srcEvent(txfSrc),
        .pending(txfPend),
        .rdAns(txfAns)
    );

    fpi_irq_group #(
        .WIDTH(8),
        .EN_ADDR(ADDR_RXF1_EN),
        .STS_ADDR(ADDR_RXF1_STS)
    ) u_rxf1 (
        .clock(clock),
        .arst_n(arst_n),
        .acc(acc),
        .srcEvent(rxf1Src),
        .pending(rxf1Pend),
        .rdAns(rxf1Ans)
    );

    fpi_irq_group #(
        .WIDTH(6),
        .EN_ADDR(ADDR_RXF2_EN),
        .STS_ADDR(ADDR_RXF2_STS)
    ) u_rxf2 (
        .clock(clock),
        .arst_n(arst_n),
        .acc(acc),
        .srcEvent(rxf2Src),
        .pending(rxf2Pend),
        .rdAns(rxf2Ans)
    );

    fpi_irq_group #(
        .WIDTH(3),
        .EN_ADDR(ADDR_PLCP_EN),
        .STS_ADDR(ADDR_PLCP_STS)
    ) u_plcp (
        .clock(clock),
        .arst_n(arst_n),
        .acc(acc),
        .srcEvent(plcpChg),
        .pending(plcpPend),
        .rdAns(plcpAns)
    );

    // Line interface registers sit at their own addresses
    fpi_irq_group #(
        .WIDTH(4),
        .EN_ADDR(ADDR_LIU_EN),
        .STS_ADDR(ADDR_LIU_STS) // R17
    ) u_liu (
        .clock(clock),
        .arst_n(arst_n),
        .acc(acc),
        .srcEvent(liuChg), // R15
        .pending(liuPend),
        .rdAns(liuAns)
    );

    fpi_perf_counters #(.NUM(CNT_NUM)) u_cnt (
        .clock(clock),
        .arst_n(arst_n),
        .acc(acc),
        .cntInc(cntInc),
        .rdAns(cntAns)
    );

    // ======================================================================
    // Block level
    // ======================================================================
    logic [7:0] blkEn_ff;
    logic [7:0] nxt_blkEn;
    logic [7:0] blkSts;
    wire blkEnHit = (syncAddr == ADDR_BLK_EN); // R16
    wire blkStsHit = (syncAddr == ADDR_BLK_STS); // R16

    always_comb begin
        blkSts = 8'h00;
        blkSts[BLK_TXF] = txfPend; // R9
        blkSts[BLK_RXF] = rxf1Pend | rxf2Pend;
        blkSts[BLK_PLCP] = plcpPend;
        blkSts[BLK_LIU] = liuPend;
    end

    assign nxt_blkEn = (wrStb & blkEnHit) ? syncData : blkEn_ff;
    wire irqAny = |(blkSts & blkEn_ff); // R8 R18

    // ======================================================================
    // Read multiplexer and bus answer
    // ======================================================================
    wire anyHit = txfAns.hit | rxf1Ans.hit | rxf2Ans.hit | plcpAns.hit | liuAns.hit
                  | cntAns.hit | blkEnHit | blkStsHit;
    wire [7:0] grpData = (txfAns.hit ? txfAns.data : 8'h00)
                       | (rxf1Ans.hit ? rxf1Ans.data : 8'h00)
                       | (rxf2Ans.hit ? rxf2Ans.data : 8'h00)
                       | (plcpAns.hit ? plcpAns.data : 8'h00)
                       | (liuAns.hit ? liuAns.data : 8'h00)
                       | (cntAns.hit ? cntAns.data : 8'h00);
    wire [7:0] blkData = blkEnHit ? blkEn_ff : (blkStsHit ? blkSts : 8'h00);
    wire [7:0] rdData = anyHit ? (grpData | blkData) : 8'h00;
    wire nxt_readyN = ~((rdStb | wrStb) | (~hostReadyN & (rdReq | wrReq)));

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            blkEn_ff <= BLK_EN_RST;
            hostDataOut <= 8'h00;
            hostDataOe <= 1'b0;
            hostReadyN <= 1'b1;
            irqReqN <= 1'b1;
        end else begin
            blkEn_ff <= nxt_blkEn;
            if (rdStb) begin
                hostDataOut <= rdData; // R3
            end
            hostDataOe <= rdReq;
            hostReadyN <= nxt_readyN;
            irqReqN <= ~irqAny; // R8
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    irqRaise_a: assert property (@(posedge clock) disable iff (!arst_n) // R8
        irqAny |=> !irqReqN)
        else $error("request not raised for enabled pending source");
    irqBlockGate_a: assert property (@(posedge clock) disable iff (!arst_n) // R18
        (blkEn_ff == 8'h00) |=> irqReqN)
        else $error("request raised with all blocks disabled");
    readData_a: assert property (@(posedge clock) disable iff (!arst_n) // R3
        rdStb |=> (hostDataOut == $past(rdData)) && !hostReadyN)
        else $error("read answer wrong or not acknowledged");
    readyHold_a: assert property (@(posedge clock) disable iff (!arst_n) // R2
        (!hostReadyN && !rdReq && !wrReq) |=> hostReadyN)
        else $error("ready held after strobe release");
    liuChange_a: assert property (@(posedge clock) disable iff (!arst_n) // R15
        (liuDefect != liuPrev_ff) |=> (u_liu.sts_ff != 4'h0))
        else $error("line interface change not latched");
    blkEnWrite_a: assert property (@(posedge clock) disable iff (!arst_n) // R16
        (wrStb && blkEnHit) |=> (blkEn_ff == $past(syncData)))
        else $error("block enable write lost");
    txfDone_a: assert property (@(posedge clock) disable iff (!arst_n) // R10
        (|txfEvent) |=> (u_txf.sts_ff != 2'h0))
        else $error("transmit framer event not latched");
    rxfChange_a: assert property (@(posedge clock) disable iff (!arst_n) // R11
        (rxfDefect != rxfPrev_ff) |=> (u_rxf1.sts_ff[3:0] != 4'h0))
        else $error("receive framer defect change not latched");
    plcpChange_a: assert property (@(posedge clock) disable iff (!arst_n) // R14
        (plcpDefect != plcpPrev_ff) |=> (u_plcp.sts_ff != 3'h0))
        else $error("PLCP defect change not latched");
    rdUnmapped_a: assert property (@(posedge clock) disable iff (!arst_n) // R3
        (rdStb && !anyHit) |=> (hostDataOut == 8'h00))
        else $error("unmapped read returned data");
    irqSeen_c: cover property (@(posedge clock) disable iff (!arst_n)
        $fell(irqReqN));
    liuRead_c: cover property (@(posedge clock) disable iff (!arst_n)
        rdStb && liuAns.hit && (liuAns.data != 8'h00));
    blkWrite_c: cover property (@(posedge clock) disable iff (!arst_n)
        wrStb && blkEnHit);
    cntLsbFirst_c: cover property (@(posedge clock) disable iff (!arst_n)
        rdStb && (|u_cnt.lsbHit));

endmodule : fpi_framer_status

// File: fpi_host_model.sv
/*
 * Host processor model for the framer status bus: one access task.
 * Assumes pins are changed at the falling clock edge and the device
 * acknowledges by driving hostReadyN low.
 */
`timescale 1ns/1ps
// ==========================================================================
// Host model
// ==========================================================================
module fpi_host_model
    import fpi_pkg::*;
(
    input wire logic clock,
    input wire logic [7:0] hostDataOut,
    input wire logic hostReadyN,
    input wire logic hostDataOe,
    output logic hostCsN,
    output logic hostRdN,
    output logic hostWrN,
    output logic [14:0] hostAddr,
    output logic [7:0] hostDataIn
);
    initial begin
        hostCsN = 1'b1;
        hostRdN = 1'b1;
        hostWrN = 1'b1;
        hostAddr = 15'h0000;
        hostDataIn = 8'h00;
    end

    // Counter halves are fetched as two byte reads, the second from the
    // holding register; the caller picks which half goes first
    task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic ok, output logic oe);
        int n;
        ok = 1'b0;
        oe = 1'b0;
        q = 8'h00;
        @(negedge clock);
        hostAddr = a;
        hostDataIn = d;
        hostCsN = 1'b0;
        hostRdN = wr;
        hostWrN = !wr;
        for (n = 0; n < 20 && !ok; n++) begin
            @(negedge clock);
            if (hostReadyN === 1'b0) begin
                ok = 1'b1;
                q = hostDataOut;
                oe = hostDataOe;
            end
        end
        @(negedge clock);
        hostCsN = 1'b1;
        hostRdN = 1'b1;
        hostWrN = 1'b1;
        // Released lines show the inverse so stale values cannot match
        hostAddr = ~a;
        hostDataIn = ~d;
        for (n = 0; n < 20 && hostReadyN !== 1'b1; n++) @(negedge clock);
        if (hostReadyN !== 1'b1) ok = 1'b0;
        repeat (3) @(negedge clock);
    endtask : access
endmodule : fpi_host_model

// File: fpi_framer_status_tb.sv
/*
 * Self-checking bench for the framer status block: counter read-out and
 * interrupt hierarchy through the host model.
 * Assumes the design package and host model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errorCnt++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
// ==========================================================================
// Bench top
// ==========================================================================
module fpi_framer_status_tb;
    import fpi_pkg::*;
    logic clock, arst_n, hostCsN, hostRdN, hostWrN, hostReadyN, irqReqN, hostDataOe;
    logic [14:0] hostAddr;
    logic [7:0] hostDataIn, hostDataOut, lo;
    logic [14:0] up;
    fpi_txf_evt_s txfEvent;
    fpi_rxf_def_s rxfDefect;
    fpi_rxf_evt_s rxfEvent;
    fpi_plcp_def_s plcpDefect;
    fpi_liu_def_s liuDefect;
    logic [CNT_NUM-1:0] cntInc;
    logic [14:0] enAddr [5] = '{ADDR_TXF_EN, ADDR_RXF1_EN, ADDR_RXF2_EN,
        ADDR_PLCP_EN, ADDR_LIU_EN};
    int errorCnt = 0;
    int comparisons = 0;

    fpi_framer_status i_dut (.clock(clock), .arst_n(arst_n), .hostCsN(hostCsN),
        .hostRdN(hostRdN), .hostWrN(hostWrN), .hostAddr(hostAddr),
        .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .hostReadyN(hostReadyN), .irqReqN(irqReqN), .txfEvent(txfEvent),
        .rxfDefect(rxfDefect), .rxfEvent(rxfEvent), .plcpDefect(plcpDefect),
        .liuDefect(liuDefect), .cntInc(cntInc));
    fpi_host_model i_host (.clock(clock), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe), .hostReadyN(hostReadyN), .hostCsN(hostCsN), .hostRdN(hostRdN),
        .hostWrN(hostWrN), .hostAddr(hostAddr), .hostDataIn(hostDataIn));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // ======================================================================
    // Tasks
    // ======================================================================
    task automatic wrapUp();
        $display("mismatches %0d comparisons %0d", errorCnt, comparisons);
        if (errorCnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrapUp

    task automatic xfer(input logic wr, input logic [14:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic ok;
        logic oe;
        i_host.access(wr, a, d, q, ok, oe);
        if (!ok) begin
            errorCnt++;
            $display("unexpected at %0t: no acknowledge", $time);
            wrapUp();
        end
        `CHK(oe, !wr)
    endtask : xfer

    task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        `CHK(q, exp)
    endtask : rdc

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        arst_n = 1'b0;
        txfEvent = '0;
        rxfDefect = '0;
        rxfEvent = '0;
        plcpDefect = '0;
        liuDefect = '0;
        cntInc = '0;
        repeat (12) @(negedge clock);
        arst_n = 1'b1;
        repeat (3) @(negedge clock);
        rdc(ADDR_BLK_EN, BLK_EN_RST);
        rdc(ADDR_LIU_EN, SRC_EN_RST);
        rdc(15'h0000, 8'h00);
        wr(ADDR_HOLD, 8'hA5);
        rdc(ADDR_HOLD, HOLD_RST);
        for (int i = 0; i < CNT_NUM; i++) begin
            for (int k = 0; k < 257 + i; k++) begin
                @(negedge clock);
                cntInc[i] = 1'b1;
                @(negedge clock);
                cntInc[i] = 1'b0;
            end
            up = ADDR_CNT_BASE + 15'(2 * i);
            lo = 8'h01 + 8'(i);
            if (i % 2) begin
                rdc(up + 15'h0001, lo);
                rdc(ADDR_HOLD, 8'h01);
            end else begin
                rdc(up, 8'h01);
                rdc(ADDR_HOLD, lo);
            end
            rdc(up, 8'h00);
            rdc(up + 15'h0001, 8'h00);
        end
        wr(ADDR_BLK_EN, 8'h0F);
        foreach (enAddr[j]) wr(enAddr[j], 8'hFF);
        liuDefect.los = 1'b1;
        repeat (4) @(negedge clock);
        `CHK(irqReqN, 1'b0)
        rdc(ADDR_BLK_STS, 8'h08);
        rdc(ADDR_LIU_STS, 8'h04);
        rdc(ADDR_LIU_STS, 8'h00);
        `CHK(irqReqN, 1'b1)
        wr(ADDR_BLK_EN, 8'h07);
        liuDefect.los = 1'b0;
        repeat (4) @(negedge clock);
        `CHK(irqReqN, 1'b1)
        rdc(ADDR_LIU_STS, 8'h04);
        txfEvent = '1;
        rxfEvent = '1;
        rxfDefect = '1;
        plcpDefect = '1;
        @(negedge clock);
        txfEvent = '0;
        rxfEvent = '0;
        repeat (4) @(negedge clock);
        `CHK(irqReqN, 1'b0)
        rdc(ADDR_BLK_STS, 8'h07);
        rdc(ADDR_TXF_STS, 8'h03);
        rdc(ADDR_RXF1_STS, 8'hFF);
        rdc(ADDR_RXF2_STS, 8'h3F);
        rdc(ADDR_PLCP_STS, 8'h07);
        `CHK(irqReqN, 1'b1)
        wrapUp();
    end
endmodule : fpi_framer_status_tb
